// >>> hdl/ump_port_dev.sv
// serial port end: control/data registers, transmitter, filtered receiver
`timescale 1ns/1ps
module ump_port_dev (
  input wire logic mclk,
  input wire logic rst_n,
  ump_link_if.dev link,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWr,
  input wire logic sfrRd,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  input wire logic timerTick,
  input wire logic [7:0] baudReload,
  input wire logic portIntEn,
  output logic portIrq
);
  import ump_pkg::*;

  // complete state of the port
  typedef struct packed {
    logic mode;       // frame width select
    logic mce;        // address filter enable
    logic ren;        // receiver gate
    logic tb8;        // tx ninth bit
    logic rb8;        // rx ninth bit
    logic ti;         // tx done flag
    logic ri;         // rx done flag
    logic [7:0] rxBuf; // receive latch
    logic [7:0] rdata; // read data register
    logic irq;        // interrupt request
    logic txd;        // serial output
    ump_tx_t txSt;
    logic [9:0] txSh; // bits still to send after start
    logic [3:0] txCnt;
    logic [7:0] txTim; // tx copy of baud timer
    logic txHalf;     // overflow divide by two
    logic rxS1;       // line synchroniser
    logic rxS2;
    logic rxPrev;     // for falling edge detect
    ump_rx_t rxSt;
    logic rxPh;       // half-bit phase
    logic [9:0] rxSh;
    logic [3:0] rxCnt;
    logic [7:0] rxTim; // rx copy of baud timer
  } ump_dev_st_t;

  ump_dev_st_t s_r;
  ump_dev_st_t s_nxt;

  // register port decode
  logic wrCtl;
  logic wrData;
  logic [7:0] ctlView;
  assign wrCtl = sfrWr && (sfrAddr == CTL_ADDR);
  assign wrData = sfrWr && (sfrAddr == DATA_ADDR);
  // control readback, bit 6 forced high
  assign ctlView = {s_r.mode, 1'b1, s_r.mce, s_r.ren, s_r.tb8, s_r.rb8, s_r.ti, s_r.ri};

  // next-state logic
  always_comb begin
    logic txOvf;
    logic txBit;
    logic rxOvf;
    logic fall;
    logic startDet;
    logic hwTi;
    logic hwRi;
    logic r9;
    logic [7:0] rdat;
    logic [9:0] rsh;
    logic [3:0] need;
    txOvf = 1'b0;
    txBit = 1'b0;
    rxOvf = 1'b0;
    fall = 1'b0;
    startDet = 1'b0;
    hwTi = 1'b0;
    hwRi = 1'b0;
    r9 = 1'b0;
    rdat = 8'h00;
    rsh = s_r.rxSh;
    need = s_r.mode ? FRAME9_BITS : FRAME8_BITS;
    s_nxt = s_r;

    // control writes; bit 6 is dropped
    if (wrCtl) begin
      s_nxt.mode = sfrWdata[CTL_MODE_BIT];
      s_nxt.mce = sfrWdata[CTL_MCE_BIT];
      s_nxt.ren = sfrWdata[CTL_REN_BIT];
      s_nxt.tb8 = sfrWdata[CTL_TB8_BIT];
      s_nxt.rb8 = sfrWdata[CTL_RB8_BIT];
      s_nxt.ti = sfrWdata[CTL_TI_BIT];
      s_nxt.ri = sfrWdata[CTL_RI_BIT];
    end

    // registered read data
    if (sfrRd) begin
      if (sfrAddr == CTL_ADDR) begin
        s_nxt.rdata = ctlView;
      end else if (sfrAddr == DATA_ADDR) begin
        s_nxt.rdata = s_r.rxBuf;
      end else begin
        s_nxt.rdata = 8'h00;
      end
    end

    // tx timer: overflow at twice the bit rate
    if (timerTick) begin
      if (s_r.txTim == TIMER_TOP) begin
        s_nxt.txTim = baudReload;
        txOvf = 1'b1;
      end else begin
        s_nxt.txTim = s_r.txTim + 8'h01;
      end
    end
    if (txOvf) begin
      s_nxt.txHalf = !s_r.txHalf;
    end
    txBit = txOvf && s_r.txHalf;

    // transmitter
    if (wrData) begin
      s_nxt.txSh = {1'b1, (s_r.mode ? s_r.tb8 : 1'b1), sfrWdata};
      s_nxt.txCnt = need;
      s_nxt.txSt = TX_WAIT;
    end else begin
      case (s_r.txSt)
        TX_IDLE: begin
          s_nxt.txd = 1'b1;
        end
        TX_WAIT: begin
          // start bit at the next bit boundary
          if (txBit) begin
            s_nxt.txd = 1'b0;
            s_nxt.txSt = TX_BUSY;
          end
        end
        TX_BUSY: begin
          if (txBit) begin
            if (s_r.txCnt == 4'h0) begin
              s_nxt.txSt = TX_IDLE;
            end else begin
              s_nxt.txd = s_r.txSh[0];
              s_nxt.txSh = {1'b1, s_r.txSh[9:1]};
              s_nxt.txCnt = s_r.txCnt - 4'h1;
              // last bit out is the stop bit
              if (s_r.txCnt == 4'h1) begin
                hwTi = 1'b1;
              end
            end
          end
        end
        default: begin
          s_nxt.txSt = TX_IDLE;
        end
      endcase
    end

    // line synchroniser and edge detect
    s_nxt.rxS1 = link.farTx;
    s_nxt.rxS2 = s_r.rxS1;
    s_nxt.rxPrev = s_r.rxS2;
    fall = s_r.rxPrev && !s_r.rxS2;
    startDet = (s_r.rxSt == RX_IDLE) && s_r.ren && fall;

    // rx timer, reloaded on a start edge
    if (startDet) begin
      s_nxt.rxTim = baudReload;
    end else if (timerTick) begin
      if (s_r.rxTim == TIMER_TOP) begin
        s_nxt.rxTim = baudReload;
        rxOvf = 1'b1;
      end else begin
        s_nxt.rxTim = s_r.rxTim + 8'h01;
      end
    end

    // receiver
    case (s_r.rxSt)
      RX_IDLE: begin
        if (startDet) begin
          s_nxt.rxSt = RX_START;
          s_nxt.rxCnt = 4'h0;
        end
      end
      RX_START: begin
        // first overflow lands mid start bit
        if (rxOvf) begin
          if (!s_r.rxS2) begin
            s_nxt.rxSt = RX_DATA;
            s_nxt.rxPh = 1'b0;
          end else begin
            s_nxt.rxSt = RX_IDLE;
          end
        end
      end
      RX_DATA: begin
        if (rxOvf) begin
          if (!s_r.rxPh) begin
            s_nxt.rxPh = 1'b1;
          end else begin
            // a whole bit after the last sample
            s_nxt.rxPh = 1'b0;
            rsh = {s_r.rxS2, s_r.rxSh[9:1]};
            s_nxt.rxSh = rsh;
            s_nxt.rxCnt = s_r.rxCnt + 4'h1;
            if (s_r.rxCnt == (need - 4'h1)) begin
              s_nxt.rxSt = RX_IDLE;
              rdat = s_r.mode ? rsh[7:0] : rsh[8:1];
              r9 = s_r.mode ? rsh[8] : rsh[9];
              if (!s_r.ri && (!s_r.mce || r9)) begin
                s_nxt.rxBuf = rdat;
                s_nxt.rb8 = r9;
                hwRi = 1'b1;
              end
            end
          end
        end
      end
      default: begin
        s_nxt.rxSt = RX_IDLE;
      end
    endcase
    // reception disabled abandons any frame
    if (!s_r.ren) begin
      s_nxt.rxSt = RX_IDLE;
    end

    // hardware sets win over software clears
    if (hwTi) begin
      s_nxt.ti = 1'b1;
    end
    if (hwRi) begin
      s_nxt.ri = 1'b1;
    end
    s_nxt.irq = portIntEn && (s_nxt.ti || s_nxt.ri);
  end

  // state register with synchronous reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.mode <= CTL_RESET[CTL_MODE_BIT];
      s_r.mce <= CTL_RESET[CTL_MCE_BIT];
      s_r.ren <= CTL_RESET[CTL_REN_BIT];
      s_r.tb8 <= CTL_RESET[CTL_TB8_BIT];
      s_r.rb8 <= CTL_RESET[CTL_RB8_BIT];
      s_r.ti <= CTL_RESET[CTL_TI_BIT];
      s_r.ri <= CTL_RESET[CTL_RI_BIT];
      s_r.rxBuf <= DATA_RESET;
      s_r.txd <= 1'b1;
      s_r.txSt <= TX_IDLE;
      s_r.rxS1 <= 1'b1;
      s_r.rxS2 <= 1'b1;
      s_r.rxPrev <= 1'b1;
      s_r.rxSt <= RX_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign sfrRdata = s_r.rdata;
  assign portIrq = s_r.irq;
  assign link.devTx = s_r.txd;
endmodule : ump_port_dev

// >>> hdl/ump_pkg.sv
// shared constants and state types for the multiprocessor serial port
package ump_pkg;
  // register addresses on the special function register port
  localparam logic [7:0] CTL_ADDR = 8'h98;
  localparam logic [7:0] DATA_ADDR = 8'h99;
  // control register field positions
  localparam int CTL_MODE_BIT = 7;
  localparam int CTL_ONE_BIT = 6;
  localparam int CTL_MCE_BIT = 5;
  localparam int CTL_REN_BIT = 4;
  localparam int CTL_TB8_BIT = 3;
  localparam int CTL_RB8_BIT = 2;
  localparam int CTL_TI_BIT = 1;
  localparam int CTL_RI_BIT = 0;
  // reset values
  localparam logic [7:0] CTL_RESET = 8'h40;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // bits following the start bit: 8 data + stop, or 8 data + ninth + stop
  localparam logic [3:0] FRAME8_BITS = 4'h9;
  localparam logic [3:0] FRAME9_BITS = 4'hA;
  // baud timer overflow point
  localparam logic [7:0] TIMER_TOP = 8'hFF;
  // typical reload for 9600 (timer clock /12) and 115200 (undivided) at 24.5 MHz
  localparam logic [7:0] RELOAD_STD = 8'h96;
  localparam int SYSTEM_CLOCK_STD_KHZ = 24500;
  localparam int BAUD_SLOW = 9600;
  localparam int BAUD_FAST = 115200;
  // transmitter states
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_WAIT = 3'b010,
    TX_BUSY = 3'b100
  } ump_tx_t;
  // receiver states
  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_START = 3'b010,
    RX_DATA = 3'b100
  } ump_rx_t;
endpackage : ump_pkg

// >>> hdl/ump_link_if.sv
// serial link between the port and the far processors
`timescale 1ns/1ps
interface ump_link_if;
  logic devTx; // line driven by the port, idle high
  logic farTx; // line driven by the far processors, idle high
  modport dev (output devTx, input farTx);
  modport far (input devTx, output farTx);
endinterface : ump_link_if

// >>> hdl/ump_far_node.sv
// far processor end: 9-bit node sending address/data, address-matching receiver
`timescale 1ns/1ps
module ump_far_node #(
  parameter logic [7:0] RELOAD = ump_pkg::RELOAD_STD
) (
  input wire logic mclk,
  input wire logic rst_n,
  ump_link_if.far link,
  input wire logic timerTick,
  input wire logic sendValid,
  input wire logic sendAddr,
  input wire logic [7:0] sendData,
  output logic sendReady,
  input wire logic [7:0] ownAddrA,
  input wire logic [7:0] ownAddrB,
  input wire logic listenAll,
  input wire logic msgDone,
  output logic rxValid,
  output logic [7:0] rxData,
  output logic rxIsAddr,
  output logic selected
);
  import ump_pkg::*;

  // complete state of the node
  typedef struct packed {
    logic txd;
    logic ready;
    ump_tx_t txSt;
    logic [9:0] txSh;
    logic [3:0] txCnt;
    logic [7:0] txTim;
    logic txHalf;
    logic rxS1;
    logic rxS2;
    logic rxPrev;
    ump_rx_t rxSt;
    logic rxPh;
    logic [9:0] rxSh;
    logic [3:0] rxCnt;
    logic [7:0] rxTim;
    logic sel;        // addressed, filter open
    logic vld;
    logic [7:0] dat;
    logic isAddr;
  } ump_far_st_t;

  ump_far_st_t s_r;
  ump_far_st_t s_nxt;

  // next-state logic
  always_comb begin
    logic txOvf;
    logic txBit;
    logic rxOvf;
    logic startDet;
    logic [9:0] rsh;
    txOvf = 1'b0;
    txBit = 1'b0;
    rxOvf = 1'b0;
    startDet = 1'b0;
    rsh = s_r.rxSh;
    s_nxt = s_r;
    s_nxt.vld = 1'b0;

    // own baud timer, same reload as the port
    if (timerTick) begin
      if (s_r.txTim == TIMER_TOP) begin
        s_nxt.txTim = RELOAD;
        txOvf = 1'b1;
      end else begin
        s_nxt.txTim = s_r.txTim + 8'h01;
      end
    end
    if (txOvf) begin
      s_nxt.txHalf = !s_r.txHalf;
    end
    txBit = txOvf && s_r.txHalf;

    // transmitter, always 11-bit frames
    case (s_r.txSt)
      TX_IDLE: begin
        if (sendValid && s_r.ready) begin
          s_nxt.txSh = {1'b1, sendAddr, sendData};
          s_nxt.txCnt = FRAME9_BITS;
          s_nxt.txSt = TX_WAIT;
        end
      end
      TX_WAIT: begin
        if (txBit) begin
          s_nxt.txd = 1'b0;
          s_nxt.txSt = TX_BUSY;
        end
      end
      TX_BUSY: begin
        if (txBit) begin
          if (s_r.txCnt == 4'h0) begin
            s_nxt.txSt = TX_IDLE;
          end else begin
            s_nxt.txd = s_r.txSh[0];
            s_nxt.txSh = {1'b1, s_r.txSh[9:1]};
            s_nxt.txCnt = s_r.txCnt - 4'h1;
          end
        end
      end
      default: begin
        s_nxt.txSt = TX_IDLE;
      end
    endcase
    s_nxt.ready = (s_nxt.txSt == TX_IDLE);

    // line synchroniser and start detect
    s_nxt.rxS1 = link.devTx;
    s_nxt.rxS2 = s_r.rxS1;
    s_nxt.rxPrev = s_r.rxS2;
    startDet = (s_r.rxSt == RX_IDLE) && s_r.rxPrev && !s_r.rxS2;
    if (startDet) begin
      s_nxt.rxTim = RELOAD;
    end else if (timerTick) begin
      if (s_r.rxTim == TIMER_TOP) begin
        s_nxt.rxTim = RELOAD;
        rxOvf = 1'b1;
      end else begin
        s_nxt.rxTim = s_r.rxTim + 8'h01;
      end
    end

    // message over: ignore until the next address; an address landing now wins
    if (msgDone) begin
      s_nxt.sel = 1'b0;
    end

    // receiver with address filter
    case (s_r.rxSt)
      RX_IDLE: begin
        if (startDet) begin
          s_nxt.rxSt = RX_START;
          s_nxt.rxCnt = 4'h0;
        end
      end
      RX_START: begin
        if (rxOvf) begin
          s_nxt.rxSt = s_r.rxS2 ? RX_IDLE : RX_DATA;
          s_nxt.rxPh = 1'b0;
        end
      end
      RX_DATA: begin
        if (rxOvf) begin
          if (!s_r.rxPh) begin
            s_nxt.rxPh = 1'b1;
          end else begin
            s_nxt.rxPh = 1'b0;
            rsh = {s_r.rxS2, s_r.rxSh[9:1]};
            s_nxt.rxSh = rsh;
            s_nxt.rxCnt = s_r.rxCnt + 4'h1;
            if (s_r.rxCnt == (FRAME9_BITS - 4'h1)) begin
              s_nxt.rxSt = RX_IDLE;
              s_nxt.dat = rsh[7:0];
              s_nxt.isAddr = rsh[8];
              if (rsh[8]) begin
                // address byte: match any own address
                s_nxt.sel = (rsh[7:0] == ownAddrA) || (rsh[7:0] == ownAddrB);
                s_nxt.vld = 1'b1;
              end else begin
                s_nxt.vld = s_r.sel || listenAll;
              end
            end
          end
        end
      end
      default: begin
        s_nxt.rxSt = RX_IDLE;
      end
    endcase
  end

  // state register with synchronous reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.txd <= 1'b1;
      s_r.txSt <= TX_IDLE;
      s_r.rxS1 <= 1'b1;
      s_r.rxS2 <= 1'b1;
      s_r.rxPrev <= 1'b1;
      s_r.rxSt <= RX_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign link.farTx = s_r.txd;
  assign sendReady = s_r.ready;
  assign rxValid = s_r.vld;
  assign rxData = s_r.dat;
  assign rxIsAddr = s_r.isAddr;
  assign selected = s_r.sel;
endmodule : ump_far_node

// >>> verif/ump_link_sva.sv
// checker for frame timing on both serial lines
`timescale 1ns/1ps
module ump_link_sva (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic devTx,
  input wire logic farTx
);
  logic dq_r; // line levels one edge back
  logic fq_r;
  logic [6:0] dPos_r; // cycles since a frame start, 127 when idle
  logic [6:0] fPos_r;
  logic [6:0] dLow_r; // length of the current low run on devTx
  // track frame position; a fall only starts a frame once data bits are over
  always_ff @(posedge mclk) begin
    dq_r <= devTx;
    fq_r <= farTx;
    if (!rst_n) begin
      dPos_r <= 7'h7F;
      fPos_r <= 7'h7F;
      dLow_r <= 7'h00;
    end else begin
      dPos_r <= (dq_r && !devTx && dPos_r >= 7'd80) ? 7'd1 : dPos_r + 7'(dPos_r != 7'h7F);
      fPos_r <= (fq_r && !farTx && fPos_r >= 7'd88) ? 7'd1 : fPos_r + 7'(fPos_r != 7'h7F);
      dLow_r <= devTx ? 7'h00 : dLow_r + 7'(dLow_r != 7'h7F);
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // start of a frame on each line
  sequence s_dev_start;
    $fell(devTx) && dPos_r >= 7'd80;
  endsequence
  sequence s_far_start;
    $fell(farTx) && fPos_r >= 7'd88;
  endsequence
  a_dev_idle_rst: assert property ($rose(rst_n) |-> devTx)
    else $error("port line not idle after reset");
  a_far_idle_rst: assert property ($rose(rst_n) |-> farTx)
    else $error("far line not idle after reset");
  a_dev_start_bit: assert property (s_dev_start |-> !devTx [*8])
    else $error("port start bit too short");
  a_far_start_bit: assert property (s_far_start |-> !farTx [*8])
    else $error("far start bit too short");
  a_dev_bit_steady: assert property (dPos_r < 7'd79 && dPos_r[2:0] != 3'd7 |=> $stable(devTx))
    else $error("port line moved inside a bit");
  a_far_bit_steady: assert property (fPos_r < 7'd87 && fPos_r[2:0] != 3'd7 |=> $stable(farTx))
    else $error("far line moved inside a bit");
  a_far_stop_high: assert property (fPos_r >= 7'd80 && fPos_r < 7'd88 |-> farTx)
    else $error("far stop bit low");
  a_dev_low_run: assert property (dLow_r <= 7'd80)
    else $error("port line low beyond ten bits");
endmodule : ump_link_sva

// >>> verif/tb_top.sv
// top bench: both ends on one link, a second port fed by a hand driver
`timescale 1ns/1ps
module tb_top;
  import ump_pkg::*;
  logic mclk, rst_n, sfrWr, sfrRd, sel, sv, sa, msgDone, irqEn, la, mSel, got;
  logic tick, irqA, irqB, sRdy, fValid, fIsAddr, fSel;
  logic [7:0] sfrAddr, sfrWdata, sd, rd, rdA, rdB, fData, addrA, addrB, rel, d, w, last;
  logic [9:0] fr;
  int num_errors, n_checks, k;
  ump_link_if lnk();
  ump_link_if lnk2();
  ump_port_dev i_ump_port_dev (.mclk(mclk), .rst_n(rst_n), .link(lnk.dev), .sfrAddr(sfrAddr),
    .sfrWr(sfrWr & !sel), .sfrRd(sfrRd & !sel), .sfrWdata(sfrWdata), .sfrRdata(rdA),
    .timerTick(tick), .baudReload(rel), .portIntEn(irqEn), .portIrq(irqA));
  ump_port_dev i_ump_port_dev_b (.mclk(mclk), .rst_n(rst_n), .link(lnk2.dev), .sfrAddr(sfrAddr),
    .sfrWr(sfrWr & sel), .sfrRd(sfrRd & sel), .sfrWdata(sfrWdata), .sfrRdata(rdB),
    .timerTick(tick), .baudReload(rel), .portIntEn(irqEn), .portIrq(irqB));
  ump_far_node #(.RELOAD(8'hFC)) i_ump_far_node (.mclk(mclk), .rst_n(rst_n), .link(lnk.far),
    .timerTick(tick), .sendValid(sv), .sendAddr(sa), .sendData(sd), .sendReady(sRdy),
    .ownAddrA(addrA), .ownAddrB(addrB), .listenAll(la), .msgDone(msgDone), .rxValid(fValid),
    .rxData(fData), .rxIsAddr(fIsAddr), .selected(fSel));
  ump_link_sva i_chk (.mclk(mclk), .rst_n(rst_n), .devTx(lnk.devTx), .farTx(lnk.farTx));
  // report verdict and stop
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask : idle
  // one-cycle register write on port s
  task automatic wr(input logic s, input logic [7:0] a, input logic [7:0] v);
    @(negedge mclk);
    {sel, sfrAddr, sfrWdata, sfrWr} = {s, a, v, 1'b1};
    @(negedge mclk);
    sfrWr = 1'b0;
  endtask : wr
  // register read, result one cycle after the strobe
  task automatic rdr(input logic s, input logic [7:0] a);
    @(negedge mclk);
    {sel, sfrAddr, sfrRd} = {s, a, 1'b1};
    @(negedge mclk);
    sfrRd = 1'b0;
    @(negedge mclk);
    rd = s ? rdB : rdA;
  endtask : rdr
  // far node send, request held until ready is seen
  task automatic fsend(input logic a, input logic [7:0] v);
    int i;
    @(negedge mclk);
    {sv, sa, sd} = {1'b1, a, v};
    for (i = 0; i < 200 && sRdy !== 1'b1; i++) @(negedge mclk);
    if (i == 200) begin
      num_errors++;
      close_out();
    end
    @(negedge mclk);
    sv = 1'b0;
  endtask : fsend
  // catch the far receive pulse; the first frame also waits out the baud
  // timer's long first count after reset
  task automatic fwait();
    int i;
    got = 1'b0;
    for (i = 0; i < 400 && !got; i++) begin
      @(negedge mclk);
      got = (fValid === 1'b1);
    end
    idle(10);
  endtask : fwait
  // hand driver on the second line, bit 0 first, 8 cycles a bit
  task automatic drv(input logic [9:0] f);
    int i;
    for (i = 0; i < 10; i++) begin
      lnk2.farTx = f[i];
      idle(8);
    end
    lnk2.farTx = 1'b1;
    idle(4);
  endtask : drv
  // sample the second port's line at bit centres
  task automatic cap();
    int i;
    for (i = 0; i < 40 && lnk2.devTx !== 1'b0; i++) @(negedge mclk);
    if (i == 40) begin
      num_errors++;
      close_out();
    end
    idle(4);
    for (i = 0; i < 10; i++) begin
      fr[i] = lnk2.devTx;
      idle(8);
    end
  endtask : cap
  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    {rst_n, sfrWr, sfrRd, sel, sv, sa, msgDone, irqEn, la, mSel} = '0;
    {sfrAddr, sfrWdata, sd, last} = '0;
    tick = 1'b1;
    rel = 8'hFC;
    lnk2.farTx = 1'b1;
    num_errors = 0;
    n_checks = 0;
    k = $urandom(39649);
    addrA = 8'($urandom);
    addrB = addrA ^ 8'h5A;
    idle(6);
    rst_n = 1'b1;
    // reset values, fixed bit, unmapped place
    rdr(0, CTL_ADDR); chk("ctl", CTL_RESET, rd);
    rdr(0, DATA_ADDR); chk("data", DATA_RESET, rd);
    wr(0, CTL_ADDR, 8'h00); rdr(0, CTL_ADDR); chk("ctl", 8'h40, rd);
    rdr(0, 8'h97); chk("unmapped", 8'h00, rd);
    irqEn = 1'b1;
    // port sends address then data bytes to the far node
    for (k = 0; k < 6; k++) begin
      // last data byte reaches an unselected node only through listen-all
      la = (k == 5);
      w = k[0] ? 8'h00 : (k == 0) ? addrA : (k == 2) ? addrB : ~addrA;
      d = k[0] ? 8'($urandom) : w;
      wr(0, CTL_ADDR, k[0] ? 8'hB0 : 8'hB8);
      wr(0, DATA_ADDR, d);
      if (!k[0]) mSel = (k < 4);
      fwait();
      chk("far valid", 8'(!k[0] || mSel || la), 8'(got));
      if (got) chk("far data", d, fData);
      if (got) chk("far addr", 8'(!k[0]), 8'(fIsAddr));
      if (k == 3) begin
        msgDone = 1'b1;
        idle(1);
        msgDone = 1'b0;
        mSel = 1'b0;
      end
      idle(2);
      chk("far sel", 8'(mSel), 8'(fSel));
      rdr(0, CTL_ADDR); chk("ctl ti", k[0] ? 8'hF2 : 8'hFA, rd);
      chk("irq", 8'h01, 8'(irqA));
    end
    // far node sends; filter, latch and overrun on the port
    wr(0, CTL_ADDR, 8'hB0);
    for (k = 0; k < 3; k++) begin
      d = 8'($urandom);
      fsend(k != 0, d);
      idle(110);
      if (k == 1) last = d;
      rdr(0, CTL_ADDR); chk("ctl ri", (k == 0) ? 8'hF0 : 8'hF5, rd);
      rdr(0, DATA_ADDR); chk("rx data", last, rd);
    end
    // 8-bit frames on the second port: stop filter and gate
    last = 8'h00;
    for (k = 0; k < 4; k++) begin
      w = (k == 3) ? 8'h20 : (k == 2) ? 8'h10 : 8'h30;
      wr(1, CTL_ADDR, w);
      d = 8'($urandom);
      drv({k[0], d, 1'b0});
      if (k == 1 || k == 2) last = d;
      chk("irq8", 8'(k == 1 || k == 2), 8'(irqB));
      rdr(1, CTL_ADDR); chk("ctl8", 8'h40 | w | ((k == 1 || k == 2) ? {5'h0, k[0], 2'b01} : 8'h00), rd);
      rdr(1, DATA_ADDR); chk("rx8 data", last, rd);
    end
    // 8-bit transmit frame on the wire
    d = 8'($urandom);
    wr(1, DATA_ADDR, d);
    cap();
    chk("tx byte", d, fr[8:1]);
    chk("tx start stop", 8'h02, {6'h0, fr[9], fr[0]});
    rdr(1, CTL_ADDR); chk("ctl8 ti", 8'h62, rd);
    close_out();
  end
endmodule : tb_top
